/* rtl/fup_pkg.sv */
// Shared constants, types and helpers for the cell and MII port block.
// Assumes a core clock and a separate link clock supplied by the far side.
package fup_pkg;

  // Cell geometry: 53 bytes, indices 0 to 52, header bytes 0 to 3.
  localparam int unsigned CELL_LEN   = 53;
  localparam logic [5:0]  LAST_BYTE  = 6'h34;
  localparam logic [5:0]  HDR_LAST   = 6'h03;
  localparam logic [5:0]  HEC_BYTE   = 6'h04;
  localparam logic [7:0]  HEC_FILL   = 8'h00;

  // Idle cell contents sent when the core has nothing queued.
  localparam logic [31:0] IDLE_HDR   = 32'h0000_0001;
  localparam logic [7:0]  IDLE_FILL  = 8'h6a;

  // Multi-PHY addressing.
  localparam logic [4:0]  NULL_PORT  = 5'h1f;
  localparam logic [4:0]  LAST_MUX   = 5'h1e;
  localparam logic [1:0]  FIRST_DIR  = 2'h0;

  // Reset values of the control flops.
  localparam logic [5:0]  IDX_RST    = 6'h00;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [31:0] HDR_RST    = 32'h0000_0000;

  // Operating modes, one-hot.
  typedef enum logic [4:0] {
    MODE_SLAVE  = 5'h01,
    MODE_DIRECT = 5'h02,
    MODE_MUX    = 5'h04,
    MODE_MII    = 5'h08,
    MODE_HDLC   = 5'h10
  } fup_mode_t;

  // Cell engine states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_XFER = 2'h2
  } fup_state_t;

  // Next address of the multiplexed poll, skipping the null port.
  function automatic logic [4:0] fup_next_phy(input logic [4:0] a);
    logic [4:0] n;
    n = (a >= LAST_MUX) ? 5'h00 : a + 5'h01;
    return n;
  endfunction

  // Byte of a cell at a given index, header sent most significant first.
  function automatic logic [7:0] fup_cell_byte(input logic [31:0] hdr,
                                               input logic [7:0]  fill,
                                               input logic [5:0]  idx);
    logic [7:0] b;
    b = fill;
    case (idx)
      6'h00:    b = hdr[31:24];
      6'h01:    b = hdr[23:16];
      6'h02:    b = hdr[15:8];
      6'h03:    b = hdr[7:0];
      HEC_BYTE: b = HEC_FILL;
      default:  b = fill;
    endcase
    return b;
  endfunction

endpackage

/* rtl/fup_poll_if.sv */
// Carrier between a cell engine and its PHY poller.
// Both ends run on the link clock.
`timescale 1ns/10ps
interface fup_poll_if;
  logic       direct;
  logic       mux;
  logic       hold;
  logic [3:0] clav;
  logic       grant;
  logic [4:0] phy;
  logic [4:0] addr;

  modport poller (input direct, input mux, input hold, input clav, output grant, output phy, output addr);
  modport engine (output direct, output mux, output hold, output clav, input grant, input phy, input addr);
endinterface

/* rtl/fup_poller.sv */
// Multi-PHY poller: picks the next PHY that reports cell-available.
// Runs on the link clock; clav lines are synchronous to that clock.
`timescale 1ns/10ps
module fup_poller
  import fup_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  fup_poll_if.poller pif
);

  logic [4:0] addr_ff;
  logic [4:0] prev_ff;
  logic [4:0] phy_ff;
  logic [1:0] ptr_ff;
  logic       grant_ff;

  assign pif.addr  = addr_ff;
  assign pif.phy   = phy_ff;
  assign pif.grant = grant_ff;

  // Address presented on the pins; frozen on the chosen PHY during a cell.
  always_ff @(posedge clk_i) begin
    if (rst_i || !pif.mux) begin
      addr_ff <= NULL_PORT;
      prev_ff <= NULL_PORT;
    end else if (pif.hold || grant_ff) begin
      addr_ff <= phy_ff;
      prev_ff <= NULL_PORT; // Stale answers are never used after a cell.
    end else begin
      prev_ff <= addr_ff;
      addr_ff <= fup_next_phy(addr_ff);
    end
  end

  // Grant one PHY whose latest answer said it has room or a cell.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grant_ff <= 1'b0;
      phy_ff   <= NULL_PORT;
      ptr_ff   <= FIRST_DIR;
    end else if (pif.hold || grant_ff) begin
      grant_ff <= 1'b0;
    end else if (pif.mux) begin
      grant_ff <= pif.clav[0] && (prev_ff != NULL_PORT);
      phy_ff   <= prev_ff;
    end else if (pif.direct) begin
      grant_ff <= pif.clav[ptr_ff];
      phy_ff   <= {3'h0, ptr_ff};
      ptr_ff   <= ptr_ff + 2'h1;
    end else begin
      grant_ff <= 1'b0;
    end
  end

endmodule // fup_poller

/* rtl/fup_port.sv */
// Pin-level cell, MII and modem handshake port of the fast serial controller.
// Link pins run on link_clk_i from the PHY or master; core ports on clk_i.
`timescale 1ns/10ps

// Operation
// - Direct polling master serves up to four PHYs.
// - Mux polling addresses 0-30; 31 is null.
// - Master transmit enable only with valid data.
// - Slave transmit cell-available only when cell fits.
// - Master start-of-cell marks the first byte.
// - Master receive enable: sample next cycle end.
// - Receive bus driven only after enable cycles.
// - Slave marks first receive byte with start-of-cell.
// - Slave receive cell-available only with whole cell.
// - TX_EN high throughout MII frame transmission.
// - TX_ER forces the PHY to propagate errors.
// - Carrier without RX_DV means broken header.
// - RTS low requests; CTS low accepts; asynchronous.
// - Idle cells fill gaps; cells are 53 bytes.
// - Bit 7 is the octet's most significant bit.
module fup_port
  import fup_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        link_clk_i,
  input  wire logic [4:0]  mode_i,
  input  wire logic        tx_cell_req_i,
  input  wire logic [31:0] tx_cell_hdr_i,
  input  wire logic [7:0]  tx_cell_fill_i,
  output logic             tx_cell_ack_o,
  output logic             rx_cell_o,
  output logic [31:0]      rx_cell_hdr_o,
  input  wire logic        mii_tx_req_i,
  input  wire logic        mii_tx_err_i,
  output logic             mii_bad_hdr_o,
  output logic             mii_col_o,
  output logic             mii_crs_o,
  output logic             mii_rx_err_o,
  input  wire logic        hdlc_send_req_i,
  output logic             hdlc_cts_ok_o,
  output logic             rts_n_o,
  input  wire logic        cts_n_i,
  output logic [7:0]       txd_o,
  output logic             tx_enb_o,
  output logic             tx_soc_o,
  input  wire logic [7:0]  txd_i,
  input  wire logic        tx_enb_i,
  input  wire logic        tx_soc_i,
  output logic             tx_clav_o,
  input  wire logic [3:0]  tx_clav_i,
  output logic [4:0]       tx_addr_o,
  output logic [7:0]       rxd_o,
  output logic             rxd_oe_o,
  output logic             rx_soc_o,
  output logic             rx_clav_o,
  output logic             rx_enb_o,
  input  wire logic [7:0]  rxd_i,
  input  wire logic        rx_enb_i,
  input  wire logic        rx_soc_i,
  input  wire logic [3:0]  rx_clav_i,
  output logic [4:0]       rx_addr_o,
  output logic             mii_tx_en_o,
  output logic             mii_tx_er_o,
  input  wire logic        mii_col_i,
  input  wire logic        mii_crs_i,
  input  wire logic        mii_rx_dv_i,
  input  wire logic        mii_rx_er_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // Crossings from the core into the link domain.

  logic [9:0]  c2l_meta_ff;
  logic [9:0]  c2l_ff;
  logic        lrst;
  logic [4:0]  lmode;
  logic        treq_s;
  logic        mii_en_s;
  logic        mii_er_s;
  logic        rack_s;
  logic        rack_ff;

  // Two flops per level; the mode is quasi-static and changed only while idle.
  always_ff @(posedge link_clk_i) begin
    c2l_meta_ff <= {rst_i, mode_i, tx_cell_req_i, mii_tx_req_i, mii_tx_err_i, rack_ff};
    c2l_ff      <= c2l_meta_ff;
  end

  assign {lrst, lmode, treq_s, mii_en_s, mii_er_s, rack_s} = c2l_ff;

  logic is_slave;
  logic is_master;
  logic is_mii;

  assign is_slave  = (lmode == MODE_SLAVE);
  assign is_master = (lmode == MODE_DIRECT) || (lmode == MODE_MUX);
  assign is_mii    = (lmode == MODE_MII);

  ////////////////////////////////////////////////////////////////////////////////
  // Pollers for the transmit and receive directions in master mode.

  fup_poll_if tx_pif ();
  fup_poll_if rx_pif ();

  fup_poller u_tx_poll (
    .clk_i (link_clk_i),
    .rst_i (lrst),
    .pif   (tx_pif.poller)
  );

  fup_poller u_rx_poll (
    .clk_i (link_clk_i),
    .rst_i (lrst),
    .pif   (rx_pif.poller)
  );

  fup_state_t snd_st_ff;
  fup_state_t rcv_st_ff;
  logic       rx_free;
  logic       rreq_ff;

  // Poller inputs; in mux mode bit 0 is the shared clav line.
  assign tx_pif.direct = (lmode == MODE_DIRECT);
  assign tx_pif.mux    = (lmode == MODE_MUX);
  assign tx_pif.clav   = tx_clav_i;
  assign tx_pif.hold   = (snd_st_ff == ST_XFER);
  assign rx_pif.direct = (lmode == MODE_DIRECT);
  assign rx_pif.mux    = (lmode == MODE_MUX);
  assign rx_pif.clav   = rx_clav_i;
  assign rx_pif.hold   = (rcv_st_ff == ST_XFER) || !rx_free;
  assign tx_addr_o     = tx_pif.addr;
  assign rx_addr_o     = rx_pif.addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Cell sender: transmit bus as master, receive bus as slave.

  logic [5:0] snd_idx_ff;
  logic       snd_user_ff;
  logic       tdone_ff;
  logic [7:0] out_byte_ff;
  logic       tx_enb_ff;
  logic       tx_soc_ff;
  logic       rxd_oe_ff;
  logic       rx_soc_ff;
  logic       rx_clav_ff;
  logic       snd_adv;
  logic [7:0] snd_byte;

  // Master sends every cycle of a cell; slave only when the master enables.
  assign snd_adv  = (snd_st_ff == ST_XFER) && (is_master || (is_slave && rx_enb_i));
  assign snd_byte = snd_user_ff ? fup_cell_byte(tx_cell_hdr_i, tx_cell_fill_i, snd_idx_ff)
                                : fup_cell_byte(IDLE_HDR, IDLE_FILL, snd_idx_ff);

  // Sender state, byte index and the user-cell completion level.
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      snd_st_ff   <= ST_IDLE;
      snd_idx_ff  <= IDX_RST;
      snd_user_ff <= 1'b0;
      tdone_ff    <= 1'b0;
      rx_clav_ff  <= 1'b0;
    end else begin
      if (!treq_s) begin
        tdone_ff <= 1'b0;
      end
      unique case (snd_st_ff)
        ST_IDLE: begin
          if (is_master && tx_pif.grant) begin
            snd_st_ff   <= ST_XFER;
            snd_user_ff <= treq_s && !tdone_ff;
          end else if (is_slave && treq_s && !tdone_ff) begin
            snd_st_ff   <= ST_XFER;
            snd_user_ff <= 1'b1;
            rx_clav_ff  <= 1'b1;
          end
          snd_idx_ff <= IDX_RST;
        end
        ST_XFER: begin
          if (!is_master && !is_slave) begin
            snd_st_ff  <= ST_IDLE;
            rx_clav_ff <= 1'b0;
          end else if (snd_adv) begin
            snd_idx_ff <= snd_idx_ff + 6'h01;
            if (snd_idx_ff == LAST_BYTE) begin
              snd_st_ff  <= ST_IDLE;
              rx_clav_ff <= 1'b0;
              if (snd_user_ff) begin
                tdone_ff <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // Pin flops of the sender; bit 7 of each byte is its most significant bit.
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      out_byte_ff <= BYTE_RST;
      tx_enb_ff   <= 1'b0;
      tx_soc_ff   <= 1'b0;
      rxd_oe_ff   <= 1'b0;
      rx_soc_ff   <= 1'b0;
    end else begin
      if (snd_adv) begin
        out_byte_ff <= snd_byte;
      end
      tx_enb_ff <= snd_adv && is_master;
      tx_soc_ff <= snd_adv && is_master && (snd_idx_ff == IDX_RST);
      rxd_oe_ff <= snd_adv && is_slave;
      rx_soc_ff <= snd_adv && is_slave && (snd_idx_ff == IDX_RST);
    end
  end

  assign txd_o     = out_byte_ff;
  assign rxd_o     = out_byte_ff;
  assign tx_enb_o  = tx_enb_ff;
  assign tx_soc_o  = tx_soc_ff;
  assign rxd_oe_o  = rxd_oe_ff;
  assign rx_soc_o  = rx_soc_ff;
  assign rx_clav_o = rx_clav_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Cell receiver: receive bus as master, transmit bus as slave.

  logic [5:0]  rcv_idx_ff;
  logic [5:0]  ecnt_ff;
  logic        rx_enb_ff;
  logic        smp_ff;
  logic        tx_clav_ff;
  logic [31:0] rhdr_ff;
  logic        smp;
  logic        bsoc;
  logic [7:0]  bdata;
  logic [5:0]  bidx;
  logic        take;

  assign rx_free = !rreq_ff && !rack_s;
  assign smp     = is_master ? smp_ff : (is_slave && tx_enb_i);
  assign bsoc    = is_master ? rx_soc_i : tx_soc_i;
  assign bdata   = is_master ? rxd_i : txd_i;
  assign take    = smp && (bsoc || (rcv_st_ff == ST_XFER));
  assign bidx    = bsoc ? IDX_RST : rcv_idx_ff;

  // Receive enable in master mode: one enable per byte, 53 per cell.
  always_ff @(posedge link_clk_i) begin
    if (lrst || !is_master) begin
      rx_enb_ff <= 1'b0;
      ecnt_ff   <= IDX_RST;
      smp_ff    <= 1'b0;
    end else begin
      smp_ff <= rx_enb_ff;
      if (rx_pif.grant) begin
        rx_enb_ff <= 1'b1;
        ecnt_ff   <= IDX_RST;
      end else if (rx_enb_ff) begin
        ecnt_ff <= ecnt_ff + 6'h01;
        if (ecnt_ff == LAST_BYTE) begin
          rx_enb_ff <= 1'b0;
        end
      end
    end
  end

  // Byte capture, header collection and the hand-off request to the core.
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      rcv_st_ff  <= ST_IDLE;
      rcv_idx_ff <= IDX_RST;
      rhdr_ff    <= HDR_RST;
      rreq_ff    <= 1'b0;
      tx_clav_ff <= 1'b0;
    end else begin
      tx_clav_ff <= is_slave && rx_free && (rcv_st_ff == ST_IDLE);
      if (rack_s) begin
        rreq_ff <= 1'b0;
      end
      if (is_master && rx_pif.grant) begin
        rcv_st_ff  <= ST_XFER;
        rcv_idx_ff <= IDX_RST;
      end else if (!is_master && !is_slave) begin
        rcv_st_ff <= ST_IDLE;
      end else if (take) begin
        rcv_st_ff  <= ST_XFER;
        rcv_idx_ff <= bidx + 6'h01;
        if (bidx <= HDR_LAST) begin
          rhdr_ff <= {rhdr_ff[23:0], bdata};
        end
        if (bidx == LAST_BYTE) begin
          rcv_st_ff <= ST_IDLE;
          rreq_ff   <= 1'b1;
        end
      end
    end
  end

  assign tx_clav_o = tx_clav_ff;
  assign rx_enb_o  = rx_enb_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // MII control pins and broken-header detection.

  logic mii_tx_en_ff;
  logic mii_tx_er_ff;
  logic crs_only_ff;
  logic bad_tog_ff;

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      mii_tx_en_ff <= 1'b0;
      mii_tx_er_ff <= 1'b0;
      crs_only_ff  <= 1'b0;
      bad_tog_ff   <= 1'b0;
    end else begin
      mii_tx_en_ff <= is_mii && mii_en_s;
      mii_tx_er_ff <= is_mii && mii_er_s;
      crs_only_ff  <= is_mii && mii_crs_i && !mii_rx_dv_i;
      if (is_mii && mii_crs_i && !mii_rx_dv_i && !crs_only_ff) begin
        bad_tog_ff <= !bad_tog_ff;
      end
    end
  end

  assign mii_tx_en_o = mii_tx_en_ff;
  assign mii_tx_er_o = mii_tx_er_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Crossings from the link into the core domain, and the core-side logic.

  logic [6:0]  l2c_meta_ff;
  logic [6:0]  l2c_ff;
  logic        bad_old_ff;
  logic        rx_cell_ff;
  logic [31:0] rx_hdr_ff;
  logic        bad_hdr_ff;
  logic        rts_n_ff;
  logic        cts_ok_ff;

  // Two flops per level or toggle; RTS and CTS have no timing to the data.
  always_ff @(posedge clk_i) begin
    l2c_meta_ff <= {tdone_ff, rreq_ff, bad_tog_ff, mii_col_i, mii_crs_i, mii_rx_er_i, cts_n_i};
    l2c_ff      <= l2c_meta_ff;
  end

  // Receive hand-off: header word is stable while the request stands.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rack_ff    <= 1'b0;
      rx_cell_ff <= 1'b0;
      rx_hdr_ff  <= HDR_RST;
      bad_old_ff <= 1'b0;
      bad_hdr_ff <= 1'b0;
    end else begin
      rx_cell_ff <= l2c_ff[5] && !rack_ff;
      if (l2c_ff[5] && !rack_ff) begin
        rack_ff   <= 1'b1;
        rx_hdr_ff <= rhdr_ff;
      end else if (!l2c_ff[5]) begin
        rack_ff <= 1'b0;
      end
      bad_old_ff <= l2c_ff[4];
      bad_hdr_ff <= l2c_ff[4] ^ bad_old_ff;
    end
  end

  // Modem request: RTS driven low while the core asks to send in HDLC mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_n_ff  <= 1'b1;
      cts_ok_ff <= 1'b0;
    end else begin
      rts_n_ff  <= !((mode_i == MODE_HDLC) && hdlc_send_req_i);
      cts_ok_ff <= (mode_i == MODE_HDLC) && hdlc_send_req_i && !l2c_ff[0];
    end
  end

  assign tx_cell_ack_o = l2c_ff[6];
  assign rx_cell_o     = rx_cell_ff;
  assign rx_cell_hdr_o = rx_hdr_ff;
  assign mii_bad_hdr_o = bad_hdr_ff;
  assign mii_col_o     = l2c_ff[3];
  assign mii_crs_o     = l2c_ff[2];
  assign mii_rx_err_o  = l2c_ff[1];
  assign hdlc_cts_ok_o = cts_ok_ff;
  assign rts_n_o       = rts_n_ff;

endmodule // fup_port

/* testbench/fup_port_asserts.sv */
// Pin checks of the cell, MII and modem port.
// Bound into fup_port; cell pins use the link clock.
`timescale 1ns/10ps
module fup_port_asserts
  import fup_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       link_clk_i,
  input wire logic [4:0] mode_i,
  input wire logic       hdlc_send_req_i,
  input wire logic       hdlc_cts_ok_o,
  input wire logic       rts_n_o,
  input wire logic       tx_enb_o,
  input wire logic       tx_soc_o,
  input wire logic [3:0] tx_clav_i,
  input wire logic [4:0] tx_addr_o,
  input wire logic       rx_enb_o,
  input wire logic       rx_enb_i,
  input wire logic       rxd_oe_o,
  input wire logic       rx_soc_o,
  input wire logic       mii_tx_en_o
);
  logic [6:0] tx_run_ff;
  logic [6:0] rx_run_ff;

  default clocking @(posedge link_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // Length of the current run of transmit enable cycles.
  always_ff @(posedge link_clk_i) begin
    tx_run_ff <= (rst_i || !tx_enb_o) ? 7'h00 : tx_run_ff + 7'h01;
  end

  // Length of the current run of receive enable cycles.
  always_ff @(posedge link_clk_i) begin
    rx_run_ff <= (rst_i || !rx_enb_o) ? 7'h00 : rx_run_ff + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // A transmit cell begins when enable first rises.
  sequence s_tx_start;
    !tx_enb_o ##1 tx_enb_o;
  endsequence
  property p_soc_first;
    tx_enb_o |-> tx_soc_o == !$past(tx_enb_o);
  endproperty
  a_soc_first: assert property (p_soc_first) else $error("soc off first byte");
  property p_tx_len;
    $fell(tx_enb_o) |-> tx_run_ff == 7'h35;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx cell not 53 bytes");
  property p_rx_len;
    $fell(rx_enb_o) |-> rx_run_ff == 7'h35;
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("rx enable run not 53");
  property p_tx_room;
    s_tx_start |-> $past(|tx_clav_i, 2) || $past(|tx_clav_i, 3) || $past(|tx_clav_i, 4);
  endproperty
  a_tx_room: assert property (p_tx_room) else $error("cell sent without room");
  property p_no_null;
    (mode_i == MODE_MUX && tx_enb_o) |-> tx_addr_o != NULL_PORT;
  endproperty
  a_no_null: assert property (p_no_null) else $error("cell sent to null port");
  property p_addr_hold;
    tx_enb_o |-> $stable(tx_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in a cell");
  property p_rxd_oe;
    rxd_oe_o |-> $past(rx_enb_i);
  endproperty
  a_rxd_oe: assert property (p_rxd_oe) else $error("rx bus driven unasked");
  property p_rx_soc;
    rx_soc_o |-> rxd_oe_o;
  endproperty
  a_rx_soc: assert property (p_rx_soc) else $error("soc with bus released");
  property p_mii_en;
    mii_tx_en_o |-> mode_i == MODE_MII;
  endproperty
  a_mii_en: assert property (p_mii_en) else $error("tx enable outside MII");
  property p_rts;
    @(posedge clk_i) !rts_n_o |-> $past(hdlc_send_req_i) && $past(mode_i) == MODE_HDLC;
  endproperty
  a_rts: assert property (p_rts) else $error("rts without request");
  property p_cts;
    @(posedge clk_i) hdlc_cts_ok_o |-> !rts_n_o;
  endproperty
  a_cts: assert property (p_cts) else $error("cts ok without rts");
endmodule // fup_port_asserts

bind fup_port fup_port_asserts u_chk (.*);

/* testbench/fup_phy_model.sv */
// Behavioural cell PHY facing the master side of the port.
// Runs on the link clock; the bench sets room and cell supply.
`timescale 1ns/10ps
module fup_phy_model
  import fup_pkg::*;
#(
  parameter logic [4:0]  PHY_ADDR = 5'h05,
  parameter logic [31:0] RX_HDR   = 32'h0a0b_0c0d
)(
  input  wire logic        link_clk_i,
  input  wire logic [4:0]  mode_i,
  input  wire logic        room_i,
  input  wire logic        have_i,
  input  wire logic [7:0]  txd_o,
  input  wire logic        tx_enb_o,
  input  wire logic        tx_soc_o,
  input  wire logic [4:0]  tx_addr_o,
  input  wire logic        rx_enb_o,
  input  wire logic [4:0]  rx_addr_o,
  output logic [3:0]       tx_clav_i,
  output logic [3:0]       rx_clav_i,
  output logic [7:0]       rxd_i,
  output logic             rx_soc_i,
  output logic [31:0]      u_hdr_o,
  output logic [4:0]       u_addr_o,
  output logic [7:0]       u_last_o,
  output int               idle_cnt_o
);
  logic [31:0] cap;
  logic [5:0]  tidx;
  logic [5:0]  ridx;
  logic [4:0]  sa;
  logic        mux;

  initial begin
    {tx_clav_i, rx_clav_i, rxd_i, rx_soc_i, tidx, ridx} = '0;
    idle_cnt_o = 0;
  end
  assign mux = (mode_i == MODE_MUX);

  // Clav answers an address one cycle late; line 0 in direct mode.
  always @(posedge link_clk_i) begin
    tx_clav_i <= {3'h0, room_i && (!mux || tx_addr_o == PHY_ADDR)};
    rx_clav_i <= {3'h0, have_i && (!mux || rx_addr_o == PHY_ADDR)};
  end

  // A byte follows each enable; otherwise the bus toggles.
  always @(posedge link_clk_i) begin
    if (rx_enb_o) begin
      rxd_i    <= (ridx < 6'h04) ? RX_HDR[31 - 8*ridx -: 8] : {2'h0, ridx};
      rx_soc_i <= (ridx == 6'h00);
      ridx     <= (ridx == LAST_BYTE) ? 6'h00 : ridx + 6'h01;
    end else begin
      rxd_i    <= ~rxd_i;
      rx_soc_i <= 1'b0;
    end
  end

  // Collects each sent cell, header MSB first.
  always @(posedge link_clk_i) begin
    if (tx_enb_o) begin
      tidx = tx_soc_o ? 6'h00 : tidx + 6'h01;
      if (tidx < 6'h04) cap = {cap[23:0], txd_o};
      if (tidx == 6'h00) sa = tx_addr_o;
      if (tidx == LAST_BYTE && cap == IDLE_HDR) idle_cnt_o++;
      if (tidx == LAST_BYTE && cap != IDLE_HDR) begin
        u_hdr_o  = cap;
        u_addr_o = sa;
        u_last_o = txd_o;
      end
    end
  end
endmodule // fup_phy_model

/* testbench/fup_port_bench.sv */
// Self-checking bench for fup_port with a cell PHY model.
// Core clock 10 ns, link clock 64 ns, unrelated in phase.
`timescale 1ns/10ps
module fup_port_bench
  import fup_pkg::*;
;
  localparam logic [4:0]  PHY = 5'h1e;
  localparam logic [31:0] RXH = 32'h0a0b_0c0d;
  logic        clk_i, rst_i, link_clk_i, tx_cell_req_i, mii_tx_req_i, mii_tx_err_i, room_i, have_i;
  logic        hdlc_send_req_i, cts_n_i, tx_enb_i, tx_soc_i, rx_enb_i, rx_soc_i;
  logic        mii_col_i, mii_crs_i, mii_rx_dv_i, mii_rx_er_i, tx_cell_ack_o, rx_cell_o, mii_bad_hdr_o;
  logic        mii_col_o, mii_crs_o, mii_rx_err_o, hdlc_cts_ok_o, rts_n_o, tx_enb_o, tx_soc_o, tx_clav_o;
  logic        rxd_oe_o, rx_soc_o, rx_clav_o, rx_enb_o, mii_tx_en_o, mii_tx_er_o;
  logic [4:0]  mode_i, tx_addr_o, rx_addr_o, u_addr_o;
  logic [31:0] tx_cell_hdr_i, rx_cell_hdr_o, u_hdr_o, gh;
  logic [7:0]  tx_cell_fill_i, txd_o, txd_i, rxd_o, rxd_i, u_last_o;
  logic [3:0]  tx_clav_i, rx_clav_i;
  int          idle_cnt_o, err_count, tests_run, i, n;
  int          cyc = 0;

  fup_port dut (.*);
  fup_phy_model #(.PHY_ADDR(PHY), .RX_HDR(RXH)) u_phy (.*);

  ////////////////////////////////////////////////////////////////////////
  // Core and link clocks.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.7;
    forever #32 link_clk_i = ~link_clk_i;
  end

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Bounded wait for a level.
  task automatic wt(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) begin
      @(posedge clk_i);
      #1;
    end
  endtask

  // Quiets cell traffic before a mode change.
  task automatic idle_port();
    room_i <= 1'b0;
    have_i <= 1'b0;
    repeat (600) @(posedge clk_i);
  endtask

  // One user cell, four-phase handshake.
  task automatic send(input logic [31:0] h);
    @(posedge clk_i);
    tx_cell_hdr_i  <= h;
    tx_cell_fill_i <= 8'h5c;
    tx_cell_req_i  <= 1'b1;
    wt(tx_cell_ack_o, 1'b1, 3000);
    chk("ack", 32'h1, 32'(tx_cell_ack_o));
    tx_cell_req_i <= 1'b0;
    wt(tx_cell_ack_o, 1'b0, 100);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("addr", 32'(NULL_PORT), 32'(tx_addr_o));
    chk("rts", 32'h1, 32'(rts_n_o));
    chk("enb", 32'h0, 32'(tx_enb_o));
  endtask

  // Master cells both ways in one polling mode.
  task automatic t_master(input logic [4:0] m, input logic [31:0] h);
    mode_i <= m;
    room_i <= 1'b1;
    have_i <= 1'b1;
    send(h);
    chk("u_hdr", h, u_hdr_o);
    chk("u_last", 32'h5c, 32'(u_last_o));
    if (m == MODE_MUX) chk("u_addr", 32'(PHY), 32'(u_addr_o));
    wt(rx_cell_o, 1'b1, 2000);
    chk("rx_cell", 32'h1, 32'(rx_cell_o));
    chk("rx_hdr", RXH, rx_cell_hdr_o);
    idle_port();
    chk("idle", 32'h1, 32'(idle_cnt_o > 0));
  endtask

  // Slave: write one cell, read one sent by the core.
  task automatic t_slave();
    mode_i <= MODE_SLAVE;
    wt(tx_clav_o, 1'b1, 500);
    chk("tx_clav", 32'h1, 32'(tx_clav_o));
    for (n = 0; n < 54; n++) begin
      @(posedge link_clk_i);
      tx_enb_i <= (n < 53);
      tx_soc_i <= (n == 0);
      txd_i    <= (n < 4) ? 8'(32'hc1c2_c3c4 >> (24 - 8*n)) : ~txd_i;
    end
    wt(rx_cell_o, 1'b1, 500);
    chk("slv_hdr", 32'hc1c2_c3c4, rx_cell_hdr_o);
    fork
      send(32'h0bad_cafe);
      begin
        wt(rx_clav_o, 1'b1, 2000);
        chk("rx_clav", 32'h1, 32'(rx_clav_o));
        i = 0;
        for (n = 0; n < 56; n++) begin
          @(posedge link_clk_i);
          rx_enb_i <= (n < 53);
          #1;
          if (rxd_oe_o === 1'b1 && i == 0) chk("soc", 32'h1, 32'(rx_soc_o));
          if (rxd_oe_o === 1'b1 && i < 4) gh = {gh[23:0], rxd_o};
          if (rxd_oe_o === 1'b1) i++;
        end
        chk("bytes", 32'd53, 32'(i));
        chk("gh", 32'h0bad_cafe, gh);
      end
    join
    chk("clav_end", 32'h0, 32'(rx_clav_o));
  endtask

  // MII transmit levels and receive indications.
  task automatic t_mii();
    mode_i       <= MODE_MII;
    mii_tx_req_i <= 1'b1;
    mii_tx_err_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("tx_en", 32'h1, 32'(mii_tx_en_o));
    chk("tx_er", 32'h1, 32'(mii_tx_er_o));
    mii_tx_req_i <= 1'b0;
    mii_tx_err_i <= 1'b0;
    @(posedge link_clk_i);
    {mii_crs_i, mii_col_i, mii_rx_er_i} <= 3'h7;
    wt(mii_bad_hdr_o, 1'b1, 100);
    chk("bad_hdr", 32'h1, 32'(mii_bad_hdr_o));
    chk("sense", 32'h7, 32'({mii_crs_o, mii_col_o, mii_rx_err_o}));
    @(posedge link_clk_i);
    {mii_crs_i, mii_col_i, mii_rx_er_i} <= 3'h0;
    repeat (40) @(posedge clk_i);
    chk("tx_off", 32'h0, 32'({mii_tx_en_o, mii_tx_er_o}));
    {mii_crs_i, mii_rx_dv_i} <= 2'h3;
    wt(mii_bad_hdr_o, 1'b1, 60);
    chk("bad_dv", 32'h0, 32'(mii_bad_hdr_o));
  endtask

  // Modem handshake in HDLC mode.
  task automatic t_hdlc();
    mode_i          <= MODE_HDLC;
    hdlc_send_req_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("rts_low", 32'h0, 32'(rts_n_o));
    chk("cts_wait", 32'h0, 32'(hdlc_cts_ok_o));
    cts_n_i <= 1'b0;
    wt(hdlc_cts_ok_o, 1'b1, 6);
    chk("cts_ok", 32'h1, 32'(hdlc_cts_ok_o));
    hdlc_send_req_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("rts_high", 32'h1, 32'(rts_n_o));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset spans five link edges too.
  initial begin
    {rst_i, mode_i, tx_cell_req_i, tx_cell_hdr_i, tx_cell_fill_i} = {1'b1, MODE_DIRECT, 41'h0};
    {mii_tx_req_i, mii_tx_err_i, hdlc_send_req_i, cts_n_i, txd_i, tx_enb_i, tx_soc_i} = 14'h0400;
    {rx_enb_i, mii_col_i, mii_crs_i, mii_rx_dv_i, mii_rx_er_i, room_i, have_i} = 7'h00;
    {err_count, tests_run, gh} = '0;
    repeat (30) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_master(MODE_DIRECT, 32'h1234_5678);
    t_master(MODE_MUX, 32'h2233_4455);
    t_slave();
    t_mii();
    t_hdlc();
    tally_and_finish();
  end
endmodule // fup_port_bench
